//--- verilog/t1_protection_line_selector.sv
// Function
// (R1) Copy equipment transmit stream identically onto both network lines.
// (R2) Forward exactly one received network line to the equipment output.
// (R3) Line faulty on loss of signal, out of frame or excess violations.
// (R4) Violation rate compared with rotary threshold, ten to minus three to nine.
// (R5) Active lamp of A while A selected, of B while B selected.
// (R6) Equipment lamp lit while equipment stream judged failed.
// (R7) In auto a button press swaps lines, at most once per two seconds.
// (R8) Force positions select that line unconditionally.
// (R9) Auto position selects by fault criteria.
// (R10) Bypass position engages metallic bypass and powers the unit off.
// (R11) Superframe or extended superframe framing recognised automatically.
// (R12) AMI or B8ZS coding recognised, substitution codes not errors.
// (R13) In auto a remote ground pulse swaps; next swap needs two seconds.
// (R14) Major alarm on both lines failed, equipment failed, reset, bypass.
// (R15) Minor alarm when a network line failed or a line is forced; code needs exactly one failed line and equipment sound.
// (R16) Line select output open for line A, grounded for line B.
// (R17) Auto leaves a faulty line for a healthy one, else keeps selection.
//
// Implementation choices: the AXI4-Lite register port and the address map.
module t1_protection_line_selector
   import t1_protection_pkg::*;
#(
   parameter int HOLDOFF = HOLDOFF_CYCLES
)(
   input wire logic clk,
   input wire logic rstn,
   input wire bipolar_t [1:0] netRx,
   input wire logic [1:0] netRxStrobe,
   input wire bipolar_t eqRx,
   input wire logic eqRxStrobe,
   input wire logic [1:0] modeSel,
   input wire logic [3:0] berSel,
   input wire logic manual_toggle_button,
   input wire logic remoteSwapN,
   output logic [1:0] netTxStrobe,
   output bipolar_t [1:0] netTx,
   output logic eqTxStrobe,
   output bipolar_t eqTx,
   output logic line_a_selected_indicator,
   output logic line_b_selected_indicator,
   output logic line_a_fault_indicator,
   output logic line_b_fault_indicator,
   output logic equipment_fail_indicator,
   output logic majorAlarmGround,
   output logic minorAlarmGround,
   output logic lineSelectGround,
   output logic bypassEngage,
   output logic powerOff,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Window length in bits for a rotary position; unused positions act as 3.
   function automatic logic [29:0] berWindow(input logic [3:0] pos);
      case (pos)
         4'h4: berWindow = 30'd10_000;
         4'h5: berWindow = 30'd100_000;
         4'h6: berWindow = 30'd1_000_000;
         4'h7: berWindow = 30'd10_000_000;
         4'h8: berWindow = 30'd100_000_000;
         4'h9: berWindow = 30'd1_000_000_000;
         default: berWindow = 30'd1_000;
      endcase
   endfunction : berWindow

   // Terminal bits of every fourth frame carry the fixed ESF pattern.
   function automatic logic esfMatch(input logic [23:0] h);
      esfMatch = ({h[23], h[19], h[15], h[11], h[7], h[3]} == ESF_FPS);
   endfunction : esfMatch

   // Superframe terminal bits alternate on every other frame.
   function automatic logic sfMatch(input logic [23:0] h);
      sfMatch = 1'b1;
      for (int k = 0; k < 22; k = k + 2) begin
         if (h[k] == h[k + 2]) begin
            sfMatch = 1'b0;
         end
      end
   endfunction : sfMatch

   ////////////////////////////////////////////////////////////////////////
   // Front panel and card edge pins.
   logic [7:0] pinS1_reg, pinS2_reg, pinS3_reg, pin_reg, pinPrev_reg;
   wire logic [7:0] pinRaw = {modeSel, berSel, manual_toggle_button,
                              remoteSwapN};

   // Three stages; a bit moves on only once the last two stages agree.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pinS1_reg <= PIN_RST;
         pinS2_reg <= PIN_RST;
         pinS3_reg <= PIN_RST;
         pin_reg <= PIN_RST;
         pinPrev_reg <= PIN_RST;
      end else begin
         pinS1_reg <= pinRaw;
         pinS2_reg <= pinS1_reg;
         pinS3_reg <= pinS2_reg;
         pin_reg <= (pinS2_reg & ~(pinS2_reg ^ pinS3_reg))
                  | (pin_reg & (pinS2_reg ^ pinS3_reg));
         pinPrev_reg <= pin_reg;
      end
   end

   wire logic [1:0] mode = pin_reg[7:6];
   wire logic [3:0] berPos = pin_reg[5:2];
   wire logic buttonPress = pin_reg[1] & ~pinPrev_reg[1];
   wire logic remoteGround = ~pin_reg[0] & pinPrev_reg[0];

   ////////////////////////////////////////////////////////////////////////
   // Stream monitors: index 0 and 1 are network A and B, 2 the equipment.
   bipolar_t sym [3];
   logic [2:0] stb, losV, oofV, berV, esfV, b8V;
   assign sym[0] = netRx[0];
   assign sym[1] = netRx[1];
   assign sym[2] = eqRx;
   assign stb = {eqRxStrobe, netRxStrobe};

   for (genvar i = 0; i < 3; i++) begin : gMon
      logic [7:0] zeroRun_reg, bitPos_reg, bpv_reg;
      logic [4:0] frame_reg;
      logic [23:0] fHist_reg;
      logic [29:0] win_reg;
      logic lastPos_reg, pendV_reg, b8zs_reg, slip_reg, oof_reg, esf_reg;
      logic ber_reg;
      wire logic mark = sym[i].pos | sym[i].neg;
      wire logic viol = mark & (sym[i].pos == lastPos_reg);
      // A violation in the B8ZS places is a substitution code, not an error.
      wire logic code = viol & ((zeroRun_reg == 8'h03)
                        | (pendV_reg & (zeroRun_reg == 8'h01)));
      wire logic [23:0] hNew = {fHist_reg[22:0], mark};
      wire logic winEnd = (win_reg >= berWindow(berPos) - 30'd1);

      // Zero runs, polarity, coding recognition and violation counting.
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            zeroRun_reg <= 8'h00;
            lastPos_reg <= 1'b0;
            pendV_reg <= 1'b0;
            b8zs_reg <= 1'b0;
            bpv_reg <= 8'h00;
            win_reg <= 30'h0;
            ber_reg <= 1'b0;
         end else if (stb[i]) begin
            if (mark) begin
               zeroRun_reg <= 8'h00;
               lastPos_reg <= sym[i].pos;
            end else if (zeroRun_reg != 8'hff) begin
               zeroRun_reg <= zeroRun_reg + 8'h01;
            end
            if (code) begin
               pendV_reg <= (zeroRun_reg == 8'h03);
            end else if (zeroRun_reg >= 8'h02) begin
               pendV_reg <= 1'b0;
            end
            if (code) begin
               b8zs_reg <= 1'b1; // R12
            end else if (zeroRun_reg >= LOS_ZEROS) begin
               b8zs_reg <= 1'b0;
            end
            // Rate judged once per window; the figure lags by one window.
            if (winEnd) begin
               win_reg <= 30'h0;
               bpv_reg <= 8'h00;
               ber_reg <= (bpv_reg > BER_MAX_ERRS); // R4
            end else begin
               win_reg <= win_reg + 30'h1;
               if (viol && !code && bpv_reg != 8'hff) begin
                  bpv_reg <= bpv_reg + 8'h01;
               end
            end
         end
      end

      // Framing hunt: a failed multiframe slips the frame phase by one bit.
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            bitPos_reg <= 8'h00;
            frame_reg <= 5'h00;
            fHist_reg <= 24'h0;
            slip_reg <= 1'b0;
            oof_reg <= 1'b1;
            esf_reg <= 1'b0;
         end else if (stb[i]) begin
            if (slip_reg) begin
               slip_reg <= 1'b0;
            end else if (bitPos_reg == FRAME_LAST) begin
               bitPos_reg <= 8'h00;
            end else begin
               bitPos_reg <= bitPos_reg + 8'h01;
            end
            if (bitPos_reg == 8'h00 && !slip_reg) begin
               fHist_reg <= hNew;
               frame_reg <= (frame_reg == MF_LAST) ? 5'h00
                                                   : frame_reg + 5'h01;
               if (frame_reg == MF_LAST) begin
                  if (esfMatch(hNew) || sfMatch(hNew)) begin
                     oof_reg <= 1'b0;
                     esf_reg <= esfMatch(hNew); // R11
                  end else begin
                     oof_reg <= 1'b1;
                     slip_reg <= 1'b1;
                  end
               end
            end
         end
      end

      assign losV[i] = (zeroRun_reg >= LOS_ZEROS);
      assign oofV[i] = oof_reg;
      assign berV[i] = ber_reg;
      assign esfV[i] = esf_reg;
      assign b8V[i] = b8zs_reg;
   end

   // Network lines judge all three causes, the equipment side loss or frame.
   wire logic [1:0] netFault = losV[1:0] | oofV[1:0] | berV[1:0]; // R3
   wire logic eqFail = losV[2] | oofV[2];

   ////////////////////////////////////////////////////////////////////////
   // Line selection.
   sel_t sel_reg;
   logic [27:0] hold_reg;
   wire logic isAuto = (mode == MODE_AUTO);
   wire logic swapReq = isAuto && (hold_reg == 28'h0)
                        && (buttonPress || remoteGround); // R7 R13
   wire logic curBad = (sel_reg == SEL_B) ? netFault[1] : netFault[0];
   wire logic othBad = (sel_reg == SEL_B) ? netFault[0] : netFault[1];
   sel_t other;
   assign other = (sel_reg == SEL_B) ? SEL_A : SEL_B;

   // Presses inside the hold-off are dropped, not queued.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_reg <= 28'h0;
      end else if (swapReq) begin
         hold_reg <= 28'(HOLDOFF - 1); // R7
      end else if (hold_reg != 28'h0) begin
         hold_reg <= hold_reg - 28'h1;
      end
   end

   // Forced and bypass positions win; auto swaps on request or on fault.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_reg <= SEL_A;
      end else begin
         case (mode)
            MODE_BYPASS: sel_reg <= SEL_BYP; // R10
            MODE_FORCE_A: sel_reg <= SEL_A; // R8
            MODE_FORCE_B: sel_reg <= SEL_B; // R8
            default: begin
               if (sel_reg == SEL_BYP) begin
                  sel_reg <= SEL_A;
               end else if (swapReq) begin
                  sel_reg <= other; // R7 R13
               end else if (curBad && !othBad) begin
                  sel_reg <= other; // R9 R17
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data paths and panel outputs; data paths and lamps go quiet in bypass, major alarm, bypass and power-off assert.
   wire logic byp = (sel_reg == SEL_BYP);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         netTx <= '0;
         netTxStrobe <= 2'h0;
         eqTx <= '0;
         eqTxStrobe <= 1'b0;
      end else begin
         netTx <= byp ? '0 : {eqRx, eqRx}; // R1
         netTxStrobe <= {2{eqRxStrobe & ~byp}}; // R1
         eqTx <= byp ? '0 : (sel_reg == SEL_B) ? netRx[1] : netRx[0]; // R2
         eqTxStrobe <= ~byp & ((sel_reg == SEL_B) ? netRxStrobe[1]
                                                  : netRxStrobe[0]); // R2
      end
   end

   // Major alarm rests grounded through reset, so its reset value is one.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         line_a_selected_indicator <= 1'b0;
         line_b_selected_indicator <= 1'b0;
         line_a_fault_indicator <= 1'b0;
         line_b_fault_indicator <= 1'b0;
         equipment_fail_indicator <= 1'b0;
         majorAlarmGround <= 1'b1;
         minorAlarmGround <= 1'b0;
         lineSelectGround <= 1'b0;
         bypassEngage <= 1'b0;
         powerOff <= 1'b0;
      end else begin
         line_a_selected_indicator <= (sel_reg == SEL_A); // R5
         line_b_selected_indicator <= (sel_reg == SEL_B); // R5
         line_a_fault_indicator <= ~byp & netFault[0]; // R3
         line_b_fault_indicator <= ~byp & netFault[1]; // R3
         equipment_fail_indicator <= ~byp & eqFail; // R6
         majorAlarmGround <= byp | eqFail | (&netFault); // R14
         minorAlarmGround <= ~byp & ((^netFault & ~eqFail)
                             | (mode != MODE_AUTO)); // R15
         lineSelectGround <= (sel_reg == SEL_B); // R16
         bypassEngage <= byp; // R10
         powerOff <= byp; // R10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable and level output.
   logic [3:0] intStat_reg, intEn_reg, evPrev_reg, intClr;
   sel_t selPrev_reg;
   wire logic [3:0] evNow = {1'b0, eqFail, netFault};
   wire logic [3:0] events = (evNow & ~evPrev_reg)
                           | {(sel_reg != selPrev_reg), 3'h0};
   // A new event beats a clear landing in the same cycle.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         intStat_reg <= INT_RST;
         evPrev_reg <= 4'h0;
         selPrev_reg <= SEL_A;
         irq <= 1'b0;
      end else begin
         intStat_reg <= (intStat_reg & ~intClr) | events;
         evPrev_reg <= evNow;
         selPrev_reg <= sel_reg;
         irq <= |(intStat_reg & intEn_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave; address and data may arrive in either order.
   logic [7:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic awHave_reg, wHave_reg;
   wire logic doWrite = awHave_reg & wHave_reg & ~s_axi_bvalid;
   wire logic wrHit = doWrite & wStrb_reg[0];
   assign intClr = (wrHit && awAddr_reg == ADDR_INT_CLEAR) ? wData_reg[3:0]
                                                          : 4'h0;
   status_t stat;
   assign stat = '{rsvd: '0, holdoff: (hold_reg != 28'h0),
                   b8zs: b8V[1:0], esf: esfV[1:0], bypass: byp,
                   selB: (sel_reg == SEL_B), selA: (sel_reg == SEL_A),
                   eqFail: eqFail, netFault: netFault};

   // Write side.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0;
         wStrb_reg <= 4'h0;
         awHave_reg <= 1'b0;
         wHave_reg <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         intEn_reg <= INT_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_reg <= s_axi_awaddr;
            awHave_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
            wHave_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_reg == ADDR_INT_CLEAR
                            || awAddr_reg == ADDR_INT_ENABLE) ? RESP_OKAY
                                                              : RESP_SLVERR;
            if (wrHit && awAddr_reg == ADDR_INT_ENABLE) begin
               intEn_reg <= wData_reg[3:0];
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read side; unmapped words read zero with a slave error.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            ADDR_STATUS: s_axi_rdata <= stat;
            ADDR_INT_STATUS: s_axi_rdata <= {28'h0, intStat_reg};
            ADDR_INT_ENABLE: s_axi_rdata <= {28'h0, intEn_reg};
            ADDR_INT_CLEAR: s_axi_rdata <= 32'h0;
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the selection and output logic.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_swap;
      swapReq;
   endsequence
   sequence s_autoFault;
      isAuto && !byp && curBad && !othBad && !swapReq;
   endsequence

   property p_copy;
      eqRxStrobe && !byp |=> netTx[0] == $past(eqRx) && netTx[1] == netTx[0]
                             && netTxStrobe == 2'h3;
   endproperty
   a_copy: assert property (p_copy) else $error("tx copy wrong"); // R1
   property p_fwdB;
      sel_reg == SEL_B |=> eqTx == $past(netRx[1]);
   endproperty
   a_fwdB: assert property (p_fwdB) else $error("forward B wrong"); // R2
   property p_fault;
      !byp && losV[0] |=> line_a_fault_indicator;
   endproperty
   a_fault: assert property (p_fault) else $error("los not shown"); // R3
   property p_hold;
      s_swap |=> !swapReq [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("swap in hold-off"); // R7
   property p_force;
      mode == MODE_FORCE_B [*2] |-> ##1 line_b_selected_indicator
                                    && lineSelectGround;
   endproperty
   a_force: assert property (p_force) else $error("force B ignored"); // R8
   property p_auto;
      s_autoFault |=> sel_reg != $past(sel_reg);
   endproperty
   a_auto: assert property (p_auto) else $error("no fault swap"); // R17
   property p_swap;
      s_swap and (sel_reg == SEL_A) |=> sel_reg == SEL_B ##1
                                        line_b_selected_indicator;
   endproperty
   a_swap: assert property (p_swap) else $error("swap lost"); // R13
   property p_byp;
      mode == MODE_BYPASS [*2] |-> ##1 powerOff && majorAlarmGround
                                   && !eqTxStrobe;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass wrong"); // R10
   property p_major;
      &netFault |=> majorAlarmGround;
   endproperty
   a_major: assert property (p_major) else $error("major missing"); // R14
   property p_minor;
      !byp && (mode == MODE_FORCE_A) |=> minorAlarmGround;
   endproperty
   a_minor: assert property (p_minor) else $error("minor missing"); // R15
endmodule : t1_protection_line_selector

//--- shared/t1_protection_pkg.sv
package t1_protection_pkg;
   // One bipolar line symbol: a positive or a negative mark, or a zero.
   typedef struct packed {
      logic pos;
      logic neg;
   } bipolar_t;

   // Live state word seen by software.
   typedef struct packed {
      logic [20:0] rsvd;
      logic holdoff;
      logic [1:0] b8zs;
      logic [1:0] esf;
      logic bypass;
      logic selB;
      logic selA;
      logic eqFail;
      logic [1:0] netFault;
   } status_t;

   typedef enum {SEL_A, SEL_B, SEL_BYP} sel_t;

   // Mode selector codes on the two mode pins.
   localparam logic [1:0] MODE_BYPASS = 2'h0;
   localparam logic [1:0] MODE_FORCE_A = 2'h1;
   localparam logic [1:0] MODE_AUTO = 2'h2;
   localparam logic [1:0] MODE_FORCE_B = 2'h3;

   // Pin vector {mode[1:0], ber[3:0], button, remote_n} after reset.
   localparam logic [7:0] PIN_RST = 8'h81;

   // Register byte addresses.
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_CLEAR = 8'h08;
   localparam logic [7:0] ADDR_INT_ENABLE = 8'h0c;
   localparam logic [3:0] INT_RST = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Line monitoring figures.
   localparam logic [7:0] LOS_ZEROS = 8'haf;
   localparam logic [7:0] FRAME_LAST = 8'hc0;
   localparam logic [4:0] MF_LAST = 5'h17;
   localparam logic [5:0] ESF_FPS = 6'h0b;
   localparam logic [7:0] BER_MAX_ERRS = 8'h01;

   // Swap hold-off time and its count of clock cycles.
   localparam int CLK_HZ = 100_000_000;
   localparam int HOLDOFF_MS = 2000;
   localparam int HOLDOFF_CYCLES = HOLDOFF_MS * (CLK_HZ / 1000);
endpackage : t1_protection_pkg

//--- verification/t1_span.sv
module t1_span
   import t1_protection_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic mute,
   input wire logic viol,
   output bipolar_t sym,
   output logic strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] bitNo;
   logic [4:0] frm;
   logic last;
   //////////////////////////////////////////////////////////////////////////
   // One symbol per cycle, F bit first. Odd frames carry an alternating F
   // pattern; random payload keeps the ones density far from loss level.
   always @(posedge clk or negedge rstn) begin : gen
      logic one;
      logic pol;
      if (!rstn) begin
         bitNo <= 8'h00;
         frm <= 5'h00;
         last <= 1'b0;
         sym <= '0;
         strobe <= 1'b0;
      end else begin
         one = bitNo == 8'h00 ? frm[1:0] == 2'h1 : $urandom % 4 != 0;
         pol = viol ? last : !last; // Repeated polarity makes a violation.
         strobe <= 1'b1;
         bitNo <= bitNo == FRAME_LAST ? 8'h00 : bitNo + 8'h01;
         if (bitNo == FRAME_LAST) begin
            frm <= frm == MF_LAST ? 5'h00 : frm + 5'h01;
         end
         sym <= one && !mute ? {pol, !pol} : 2'h0;
         if (one && !mute) begin
            last <= pol;
         end
      end
   end
endmodule : t1_span

//--- verification/tb_top.sv
module tb_top
   import t1_protection_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] modeSel, netTxStrobe, s_axi_bresp, s_axi_rresp, r;
   logic [3:0] berSel;
   logic manual_toggle_button, remoteSwapN, muteA, violB, muteE, eqS, sA, sB;
   logic eqTxStrobe, selA, selB, fltA, fltB, eqF, major, minor, selG, irq;
   wire logic [1:0] pw;
   bipolar_t rxA, rxB, eqRx, eqTx;
   bipolar_t [1:0] netTx;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_bready, s_axi_rready;
   logic [1:0] fm[2] = '{MODE_FORCE_A, MODE_FORCE_B};
   logic [6:0] fx[2] = '{7'b1000010, 7'b0100011};
   int errors = 0;
   int checked = 0;
   t1_span eqSide(.clk, .rstn, .mute(muteE), .viol(1'b0), .sym(eqRx),
      .strobe(eqS));
   t1_span spanA(.clk, .rstn, .mute(muteA), .viol(1'b0), .sym(rxA),
      .strobe(sA));
   t1_span spanB(.clk, .rstn, .mute(1'b0), .viol(violB), .sym(rxB),
      .strobe(sB));
   // A short hold-off keeps the toggle tests brief.
   t1_protection_line_selector #(.HOLDOFF(40)) dut(
      .clk, .rstn, .netRx({rxB, rxA}), .netRxStrobe({sB, sA}), .eqRx,
      .eqRxStrobe(eqS), .modeSel, .berSel, .manual_toggle_button,
      .remoteSwapN, .netTxStrobe, .netTx, .eqTxStrobe, .eqTx,
      .line_a_selected_indicator(selA), .line_b_selected_indicator(selB),
      .line_a_fault_indicator(fltA), .line_b_fault_indicator(fltB),
      .equipment_fail_indicator(eqF), .majorAlarmGround(major),
      .minorAlarmGround(minor), .lineSelectGround(selG),
      .bypassEngage(pw[1]), .powerOff(pw[0]), .irq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   //////////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task lamps(input logic [6:0] e);
      chk("lamps", e, {selA, selB, fltA, fltB, major, minor, selG});
   endtask : lamps
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // Each task raises its own ready line and drops the idle one.
   task axw(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      s_axi_rready <= 1'b0;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask : axw
   task axr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      s_axi_bready <= 1'b0;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : axr
   // Symbols taken at one edge must appear on the outputs one edge later.
   task strm(input logic s);
      bipolar_t e, x;
      logic st, xs;
      @(posedge clk);
      e = eqRx;
      st = eqS;
      x = s ? rxB : rxA;
      xs = s ? sB : sA;
      @(posedge clk);
      chk("netTx", {e, e}, netTx);
      chk("netTxStrobe", {st, st}, netTxStrobe);
      chk("eqTx", {xs, x}, {eqTxStrobe, eqTx});
   endtask : strm
   task end_of_test;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   //////////////////////////////////////////////////////////////////////////
   // The hang limit allows well over the expected run of some 39k cycles.
   initial begin
      #1_000_000;
      errors++;
      end_of_test;
   end
   initial begin
      void'($urandom(16));
      {modeSel, berSel, manual_toggle_button, remoteSwapN} = PIN_RST;
      {muteA, violB, muteE, s_axi_awvalid, s_axi_wvalid} = 5'h00;
      {s_axi_arvalid, s_axi_bready, s_axi_rready, s_axi_awaddr} = '0;
      {s_axi_araddr, s_axi_wdata} = '0;
      cyc(2);
      chk("majorInReset", 1'b1, major);
      cyc(2);
      rstn <= 1'b1;
      berSel <= 4'h3 + 4'($urandom % 2);
      cyc(10000);
      lamps(7'b1000000);
      chk("eqFail", 1'b0, eqF);
      strm(1'b0);
      axw(ADDR_INT_CLEAR, 32'hf);
      axw(ADDR_INT_ENABLE, 32'h9);
      chk("bresp", RESP_OKAY, r);
      axr(ADDR_INT_ENABLE);
      chk("intEnable", 32'h9, d);
      axr(8'h10);
      chk("rresp", {RESP_SLVERR, 30'h0}, {r, d[29:0]});
      axw(ADDR_STATUS, 32'h0);
      chk("bresp", RESP_SLVERR, r);
      $display("test start done");
      // Mute between two F marks so that line A keeps its framing.
      @(spanA.frm iff spanA.frm == 5'h16);
      muteA <= 1'b1;
      cyc(400);
      lamps(7'b0110011);
      strm(1'b1);
      axr(ADDR_STATUS);
      chk("status", 32'h11, d & 32'h3f);
      axr(ADDR_INT_STATUS);
      chk("intStatus", {31'h9, 1'b1}, {d[30:0], irq});
      axw(ADDR_INT_CLEAR, 32'h9);
      cyc(3);
      chk("irq", 1'b0, irq);
      muteA <= 1'b0;
      cyc(10000);
      lamps(7'b0100001);
      $display("test line loss done");
      // The second press falls inside the hold-off and must be ignored.
      for (int i = 0; i < 2; i++) begin
         manual_toggle_button <= 1'b1;
         cyc(6);
         manual_toggle_button <= 1'b0;
         cyc(10);
         lamps(7'b1000000);
      end
      cyc(60);
      remoteSwapN <= 1'b0;
      cyc(6);
      remoteSwapN <= 1'b1;
      cyc(10);
      lamps(7'b0100001);
      for (int i = 0; i < 2; i++) begin
         modeSel <= fm[i];
         cyc(10);
         lamps(fx[i]);
      end
      modeSel <= MODE_BYPASS;
      cyc(10);
      lamps(7'b0000100);
      chk("bypass", {2'b11, 2'h0}, {pw, eqTx});
      modeSel <= MODE_AUTO;
      berSel <= 4'h3;
      violB <= 1'b1;
      cyc(14000);
      chk("selA", 1'b1, selA);
      chk("fltB", 1'b1, fltB);
      muteE <= 1'b1;
      cyc(400);
      chk("eqFailMajor", 2'b11, {eqF, major});
      $display("test modes done");
      end_of_test;
   end
endmodule : tb_top
